// file: src/wff_pkg.sv
// wake-up frame filter configuration bank: offsets, field layout, reset values
// assumes a paged byte-wide host register port with 16 offsets per page
package wff_pkg;

    // ------------------------------------------------------------------
    // pages
    // ------------------------------------------------------------------
    localparam logic [1:0] PAGE_CFG    = 2'h0;
    localparam logic [1:0] PAGE_MIRROR = 2'h2;
    localparam logic [1:0] PAGE_WAKE   = 2'h3;

    // ------------------------------------------------------------------
    // offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_RX_CONFIG   = 4'hC;
    localparam logic [3:0] OFS_TX_CONFIG   = 4'hD;
    localparam logic [3:0] OFS_DATA_CONFIG = 4'hE;
    localparam logic [3:0] OFS_IRQ_MASK    = 4'hF;
    localparam logic [3:0] OFS_WAKE_MASK_0 = 4'h1;
    localparam logic [3:0] OFS_CRC_LOW     = 4'h5;
    localparam logic [3:0] OFS_CRC_HIGH    = 4'h6;
    localparam logic [3:0] OFS_OFFSETS     = 4'h7;
    localparam logic [3:0] OFS_LAST_BYTES  = 4'h8;
    localparam logic [3:0] OFS_COMMAND     = 4'h9;

    // ------------------------------------------------------------------
    // word store layout (word index = offset - first wide offset)
    // ------------------------------------------------------------------
    localparam int         NUM_FILTERS  = 4;
    localparam int         NUM_WORDS    = 9;
    localparam int         NUM_CFG      = 4;
    localparam logic [3:0] WORD_CRC_LOW = 4'h4;
    localparam logic [3:0] WORD_CRC_HI  = 4'h5;
    localparam logic [3:0] WORD_OFFSETS = 4'h6;
    localparam logic [3:0] WORD_LAST    = 4'h7;
    localparam logic [3:0] WORD_COMMAND = 4'h8;

    // ------------------------------------------------------------------
    // fields and values
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_BYTE_MASK     = 8'h77;
    localparam logic [1:0]  CMD_LAST_LANE     = 2'h1;
    localparam int          CMD_BIT_ENABLE    = 0;
    localparam int          CMD_BIT_DEST      = 1;
    localparam int          CMD_BIT_MCAST     = 2;
    localparam logic [15:0] CRC_POLY          = 16'h8005;
    localparam logic [7:0]  BYTE_RESET        = 8'h00;
    localparam logic [31:0] WORD_RESET        = 32'h0000_0000;
    localparam logic [1:0]  LANE_FIRST        = 2'h0;
    localparam logic [1:0]  LANE_LAST         = 2'h3;
    localparam int          OFFSET_UNIT_SHIFT = 1;

endpackage : wff_pkg

// file: src/wff_cfg_store.sv
// word store for the wake-up filter configuration, written one byte lane at a time
// assumes one write and one read request per cycle at most
`timescale 1ns/100ps
`default_nettype none
module wff_cfg_store #(
    parameter int WORDS = 9
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // byte write
    input  wire logic                 wrEn,
    input  wire logic [3:0]           wrWord,
    input  wire logic [1:0]           wrLane,
    input  wire logic [7:0]           wrByte,
    // byte read, data one cycle later
    input  wire logic                 rdEn,
    input  wire logic [3:0]           rdWord,
    input  wire logic [1:0]           rdLane,
    output var  logic [7:0]           rdByte,
    // whole contents
    output var  logic [WORDS*32-1:0]  words
);

    logic [WORDS*32-1:0] words_reg;
    logic [WORDS*32-1:0] words_next;
    logic [7:0]          rdByte_reg;
    logic [7:0]          rdByte_next;

    always_comb begin
        words_next  = words_reg;
        rdByte_next = rdByte_reg;
        if (wrEn && (int'(wrWord) < WORDS)) begin
            words_next[{wrWord, wrLane, 3'h0} +: 8] = wrByte;
        end
        if (rdEn) begin
            rdByte_next = (int'(rdWord) < WORDS) ? words_reg[{rdWord, rdLane, 3'h0} +: 8]
                                                 : wff_pkg::BYTE_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            words_reg  <= '0;
            rdByte_reg <= wff_pkg::BYTE_RESET;
        end else begin
            words_reg  <= words_next;
            rdByte_reg <= rdByte_next;
        end
    end

    assign words  = words_reg;
    assign rdByte = rdByte_reg;

endmodule : wff_cfg_store
`default_nettype wire

// file: src/wff_filter_config.sv
// wake-up frame filter configuration bank with page-2 configuration mirrors
// assumes a synchronous byte-wide host port, one read or write strobe per access
`timescale 1ns/100ps
`default_nettype none
module wff_filter_config (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         srst,
    // host register port
    input  wire logic [1:0]   hostPage,
    input  wire logic [3:0]   hostAddr,
    input  wire logic         hostWrite,
    input  wire logic         hostRead,
    input  wire logic [7:0]   hostWrData,
    output var  logic [7:0]   hostRdData,
    output var  logic         hostRdValid,
    // configuration registers
    output var  logic [7:0]   rxConfig,
    output var  logic [7:0]   txConfig,
    output var  logic [7:0]   dataConfig,
    output var  logic [7:0]   irqMask,
    // filter settings
    output var  logic [127:0] wakeMask,
    output var  logic [63:0]  filterCrc,
    output var  logic [35:0]  filterByteOffset,
    output var  logic [31:0]  filterLastByte,
    output var  logic [3:0]   filterEnable,
    output var  logic [3:0]   destMatchEnable,
    output var  logic [3:0]   mcastMatchEnable
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic isWide(input logic [1:0] page, input logic [3:0] addr);
        isWide = (page == wff_pkg::PAGE_WAKE) && (addr >= wff_pkg::OFS_WAKE_MASK_0)
                 && (addr <= wff_pkg::OFS_COMMAND);
    endfunction : isWide

    function automatic logic [3:0] wordOf(input logic [3:0] addr);
        wordOf = addr - wff_pkg::OFS_WAKE_MASK_0;
    endfunction : wordOf

    logic       wideWr;
    logic       wideRd;
    logic [3:0] wIdx;

    assign wideWr = hostWrite && isWide(hostPage, hostAddr);
    assign wideRd = hostRead && isWide(hostPage, hostAddr);
    assign wIdx   = wordOf(hostAddr);

    // ------------------------------------------------------------------
    // byte pointers
    // ------------------------------------------------------------------
    logic [1:0] wrPtr_reg [wff_pkg::NUM_WORDS];
    logic [1:0] wrPtr_next[wff_pkg::NUM_WORDS];
    logic [1:0] rdPtr_reg [wff_pkg::NUM_WORDS];
    logic [1:0] rdPtr_next[wff_pkg::NUM_WORDS];

    always_comb begin
        for (int i = 0; i < wff_pkg::NUM_WORDS; i++) begin
            wrPtr_next[i] = wrPtr_reg[i];
            rdPtr_next[i] = rdPtr_reg[i];
        end
        if (wideWr) begin
            wrPtr_next[wIdx] = wrPtr_reg[wIdx] + 2'h1;
        end
        if (wideRd) begin
            rdPtr_next[wIdx] = rdPtr_reg[wIdx] + 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < wff_pkg::NUM_WORDS; i++) begin
            if (srst) begin
                wrPtr_reg[i] <= wff_pkg::LANE_FIRST;
                rdPtr_reg[i] <= wff_pkg::LANE_FIRST;
            end else begin
                wrPtr_reg[i] <= wrPtr_next[i];
                rdPtr_reg[i] <= rdPtr_next[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // word store
    // ------------------------------------------------------------------
    logic [1:0]                    curWrLane;
    logic [7:0]                    storeWrByte;
    logic [7:0]                    storeRdByte;
    logic [wff_pkg::NUM_WORDS*32-1:0] words;

    assign curWrLane = wrPtr_reg[wIdx];

    always_comb begin
        storeWrByte = hostWrData;
        if (wIdx == wff_pkg::WORD_COMMAND) begin
            storeWrByte = (curWrLane <= wff_pkg::CMD_LAST_LANE)
                          ? (hostWrData & wff_pkg::CMD_BYTE_MASK) : wff_pkg::BYTE_RESET;
        end
    end

    wff_cfg_store #(
        .WORDS (wff_pkg::NUM_WORDS)
    ) u_store (
        .clk    (core_clk),
        .srst   (srst),
        .wrEn   (wideWr),
        .wrWord (wIdx),
        .wrLane (curWrLane),
        .wrByte (storeWrByte),
        .rdEn   (wideRd),
        .rdWord (wIdx),
        .rdLane (rdPtr_reg[wIdx]),
        .rdByte (storeRdByte),
        .words  (words)
    );

    assign wakeMask       = words[127:0];
    assign filterCrc      = {words[32*wff_pkg::WORD_CRC_HI +: 32],
                             words[32*wff_pkg::WORD_CRC_LOW +: 32]};
    assign filterLastByte = words[32*wff_pkg::WORD_LAST +: 32];

    // ------------------------------------------------------------------
    // page-0 configuration registers
    // ------------------------------------------------------------------
    logic [7:0] cfg_reg [wff_pkg::NUM_CFG];
    logic [7:0] cfg_next[wff_pkg::NUM_CFG];

    always_comb begin
        for (int i = 0; i < wff_pkg::NUM_CFG; i++) begin
            cfg_next[i] = cfg_reg[i];
        end
        // only page 0 stores; page-2 writes fall through untouched
        if (hostWrite && (hostPage == wff_pkg::PAGE_CFG) && (hostAddr >= wff_pkg::OFS_RX_CONFIG)) begin
            cfg_next[hostAddr[1:0]] = hostWrData;
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < wff_pkg::NUM_CFG; i++) begin
            cfg_reg[i] <= srst ? wff_pkg::BYTE_RESET : cfg_next[i];
        end
    end

    assign rxConfig   = cfg_reg[0];
    assign txConfig   = cfg_reg[1];
    assign dataConfig = cfg_reg[2];
    assign irqMask    = cfg_reg[3];

    // ------------------------------------------------------------------
    // per-filter derived settings
    // ------------------------------------------------------------------
    genvar f;
    generate
        for (f = 0; f < wff_pkg::NUM_FILTERS; f++) begin : g_filter
            logic [8:0] ofs_reg;
            logic [8:0] ofs_next;
            logic [2:0] cmd_reg;
            logic [2:0] cmd_next;
            always_comb begin
                ofs_next = {words[32*wff_pkg::WORD_OFFSETS + 8*f +: 8], 1'b0};
                cmd_next = words[32*wff_pkg::WORD_COMMAND + 4*f +: 3];
            end
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    ofs_reg <= 9'h000;
                    cmd_reg <= 3'h0;
                end else begin
                    ofs_reg <= ofs_next;
                    cmd_reg <= cmd_next;
                end
            end
            assign filterByteOffset[9*f +: 9] = ofs_reg;
            assign filterEnable[f]            = cmd_reg[wff_pkg::CMD_BIT_ENABLE];
            assign destMatchEnable[f]         = cmd_reg[wff_pkg::CMD_BIT_DEST];
            assign mcastMatchEnable[f]        = cmd_reg[wff_pkg::CMD_BIT_MCAST];
        end
    endgenerate

    // ------------------------------------------------------------------
    // read path: stage 1 selects source, stage 2 drives the port
    // ------------------------------------------------------------------
    logic       rdPend_reg,   rdPend_next;
    logic       rdStore_reg,  rdStore_next;
    logic [7:0] rdMirror_reg, rdMirror_next;
    logic [7:0] rdData_reg,   rdData_next;
    logic       rdValid_reg,  rdValid_next;

    always_comb begin
        rdPend_next   = hostRead;
        rdStore_next  = wideRd;
        rdMirror_next = wff_pkg::BYTE_RESET;
        if (hostRead && (hostPage == wff_pkg::PAGE_MIRROR)
            && (hostAddr >= wff_pkg::OFS_RX_CONFIG)) begin
            rdMirror_next = cfg_reg[hostAddr[1:0]];
        end
        rdValid_next = rdPend_reg;
        rdData_next  = rdStore_reg ? storeRdByte : rdMirror_reg;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdPend_reg   <= 1'b0;
            rdStore_reg  <= 1'b0;
            rdMirror_reg <= wff_pkg::BYTE_RESET;
            rdData_reg   <= wff_pkg::BYTE_RESET;
            rdValid_reg  <= 1'b0;
        end else begin
            rdPend_reg   <= rdPend_next;
            rdStore_reg  <= rdStore_next;
            rdMirror_reg <= rdMirror_next;
            rdData_reg   <= rdData_next;
            rdValid_reg  <= rdValid_next;
        end
    end

    assign hostRdData  = rdData_reg;
    assign hostRdValid = rdValid_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    function automatic logic wrAt(input logic [3:0] ofs);
        wrAt = hostWrite && (hostPage == wff_pkg::PAGE_WAKE) && (hostAddr == ofs);
    endfunction : wrAt

    function automatic logic mirRd(input logic [3:0] ofs);
        mirRd = hostRead && (hostPage == wff_pkg::PAGE_MIRROR) && (hostAddr == ofs);
    endfunction : mirRd

    property p_rx_mirror;
        @(posedge core_clk) disable iff (srst)
        mirRd(wff_pkg::OFS_RX_CONFIG) |-> ##2 (hostRdValid && hostRdData == $past(rxConfig, 2));
    endproperty
    a_rx_mirror: assert property (p_rx_mirror) else $error("rx config mirror wrong");

    property p_tx_mirror;
        @(posedge core_clk) disable iff (srst)
        mirRd(wff_pkg::OFS_TX_CONFIG) |-> ##2 (hostRdData == $past(txConfig, 2));
    endproperty
    a_tx_mirror: assert property (p_tx_mirror) else $error("tx config mirror wrong");

    property p_data_mirror;
        @(posedge core_clk) disable iff (srst)
        mirRd(wff_pkg::OFS_DATA_CONFIG) |-> ##2 (hostRdData == $past(dataConfig, 2));
    endproperty
    a_data_mirror: assert property (p_data_mirror) else $error("data config mirror wrong");

    property p_irq_mirror;
        @(posedge core_clk) disable iff (srst)
        mirRd(wff_pkg::OFS_IRQ_MASK) |-> ##2 (hostRdData == $past(irqMask, 2));
    endproperty
    a_irq_mirror: assert property (p_irq_mirror) else $error("irq mask mirror wrong");

    property p_mask3_lane2;
        @(posedge core_clk) disable iff (srst)
        (wrAt(4'h4) && wrPtr_reg[3] == 2'h2) |=> (wakeMask[119:112] == $past(hostWrData));
    endproperty
    a_mask3_lane2: assert property (p_mask3_lane2) else $error("mask byte misplaced");

    property p_crc_low_first;
        @(posedge core_clk) disable iff (srst)
        (wrAt(wff_pkg::OFS_CRC_LOW) && wrPtr_reg[4] == 2'h0) |=> (filterCrc[7:0] == $past(hostWrData));
    endproperty
    a_crc_low_first: assert property (p_crc_low_first) else $error("crc low byte misplaced");

    property p_crc_high_last;
        @(posedge core_clk) disable iff (srst)
        (wrAt(wff_pkg::OFS_CRC_HIGH) && wrPtr_reg[5] == 2'h3) |=> (filterCrc[63:56] == $past(hostWrData));
    endproperty
    a_crc_high_last: assert property (p_crc_high_last) else $error("crc high byte misplaced");

    property p_crc_hold;
        @(posedge core_clk) disable iff (srst)
        !wrAt(wff_pkg::OFS_CRC_LOW) |=> $stable(filterCrc[31:0]);
    endproperty
    a_crc_hold: assert property (p_crc_hold) else $error("crc changed without write");

    property p_offset_units;
        @(posedge core_clk) disable iff (srst)
        (wrAt(wff_pkg::OFS_OFFSETS) && wrPtr_reg[6] == 2'h0)
        |-> ##2 (filterByteOffset[8:0] == {$past(hostWrData, 2), 1'b0});
    endproperty
    a_offset_units: assert property (p_offset_units) else $error("offset not in word units");

    property p_last_byte;
        @(posedge core_clk) disable iff (srst)
        (wrAt(wff_pkg::OFS_LAST_BYTES) && wrPtr_reg[7] == 2'h3) |=> (filterLastByte[31:24] == $past(hostWrData));
    endproperty
    a_last_byte: assert property (p_last_byte) else $error("last byte misplaced");

    property p_ptr_wrap;
        @(posedge core_clk) disable iff (srst)
        (wideWr && curWrLane == 2'h3) |=> (wrPtr_reg[$past(wIdx)] == 2'h0);
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) else $error("byte pointer did not wrap");

    property p_reset_zero;
        @(posedge core_clk) srst |=> (hostRdData == 8'h00 && wakeMask == '0 && rxConfig == 8'h00);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("state not cleared by reset");

    property p_mirror_wr_ignored;
        @(posedge core_clk) disable iff (srst)
        (hostWrite && hostPage == wff_pkg::PAGE_MIRROR)
        |=> ($stable(rxConfig) && $stable(txConfig) && $stable(dataConfig) && $stable(irqMask));
    endproperty
    a_mirror_wr_ignored: assert property (p_mirror_wr_ignored) else $error("mirror write landed");

    property p_cmd_enable;
        @(posedge core_clk) disable iff (srst)
        (wrAt(wff_pkg::OFS_COMMAND) && wrPtr_reg[8] == 2'h0)
        |-> ##2 (filterEnable[0] == $past(hostWrData[0], 2) && mcastMatchEnable[1] == $past(hostWrData[6], 2));
    endproperty
    a_cmd_enable: assert property (p_cmd_enable) else $error("command bits wrong");

    c_mask_full: cover property (@(posedge core_clk) disable iff (srst)
        (wrAt(4'h1) && wrPtr_reg[0] == 2'h3));
    c_mirror_read: cover property (@(posedge core_clk) disable iff (srst)
        mirRd(wff_pkg::OFS_RX_CONFIG) ##2 (hostRdData != 8'h00));
    c_cmd_write: cover property (@(posedge core_clk) disable iff (srst)
        wrAt(wff_pkg::OFS_COMMAND) ##2 (filterEnable != 4'h0));

endmodule : wff_filter_config
`default_nettype wire

// file: dv/wff_host_model.sv
// host model: byte-wide paged register port master
// assumes core_clk rising edge sampling by the bank
`timescale 1ns/100ps
`default_nettype none
module wff_host_model (
    // clock
    input  wire logic       core_clk,
    // host register port
    output var  logic [1:0] hostPage,
    output var  logic [3:0] hostAddr,
    output var  logic       hostWrite,
    output var  logic       hostRead,
    output var  logic [7:0] hostWrData,
    input  wire logic [7:0] hostRdData,
    input  wire logic       hostRdValid
);
    initial begin
        hostPage   = 2'h1;
        hostAddr   = 4'h0;
        hostWrite  = 1'b0;
        hostRead   = 1'b0;
        hostWrData = 8'hA5;
    end

    // one write strobe per byte; wide words take four in succession
    task automatic wr(input logic [1:0] pg, input logic [3:0] ofs, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        hostPage   = pg;
        hostAddr   = ofs;
        hostWrData = d;
        hostWrite  = 1'b1;
        @(posedge core_clk);
        #1;
        hostWrite  = 1'b0;
        hostWrData = ~d;
    endtask : wr

    // read strobe, then wait a bounded time for the valid pulse
    task automatic rd(input logic [1:0] pg, input logic [3:0] ofs, output logic [7:0] d);
        int n;
        @(posedge core_clk);
        #1;
        hostPage = pg;
        hostAddr = ofs;
        hostRead = 1'b1;
        @(posedge core_clk);
        #1;
        hostRead = 1'b0;
        n = 0;
        while (hostRdValid !== 1'b1 && n < 4) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        d = (hostRdValid === 1'b1 && n == 1) ? hostRdData : 8'hXX;
    endtask : rd
endmodule : wff_host_model
`default_nettype wire

// file: dv/wff_filter_config_tb.sv
// testbench for the wake-up filter configuration bank
// assumes the host model drives the register port
`timescale 1ns/100ps
`default_nettype none
module wff_filter_config_tb;
    logic         core_clk;
    logic         srst;
    logic [1:0]   hostPage;
    logic [3:0]   hostAddr;
    logic         hostWrite;
    logic         hostRead;
    logic [7:0]   hostWrData;
    logic [7:0]   hostRdData;
    logic         hostRdValid;
    logic [7:0]   rxConfig, txConfig, dataConfig, irqMask;
    logic [127:0] wakeMask;
    logic [63:0]  filterCrc;
    logic [35:0]  filterByteOffset;
    logic [31:0]  filterLastByte;
    logic [3:0]   filterEnable, destMatchEnable, mcastMatchEnable;
    logic [7:0]   rdVal;
    int           miscompares = 0;
    int           checksDone  = 0;

    wff_filter_config uut (.core_clk(core_clk), .srst(srst), .hostPage(hostPage),
        .hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead),
        .hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
        .rxConfig(rxConfig), .txConfig(txConfig), .dataConfig(dataConfig),
        .irqMask(irqMask), .wakeMask(wakeMask), .filterCrc(filterCrc),
        .filterByteOffset(filterByteOffset), .filterLastByte(filterLastByte),
        .filterEnable(filterEnable), .destMatchEnable(destMatchEnable),
        .mcastMatchEnable(mcastMatchEnable));
    wff_host_model host (.core_clk(core_clk), .hostPage(hostPage), .hostAddr(hostAddr),
        .hostWrite(hostWrite), .hostRead(hostRead), .hostWrData(hostWrData),
        .hostRdData(hostRdData), .hostRdValid(hostRdValid));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    function automatic logic [31:0] wv(input logic [3:0] o);
        return {o, 4'h3, o, 4'h2, o, 4'h1, o, 4'h0};
    endfunction : wv

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        for (int o = 1; o < 16; o++) begin
            for (int l = 0; l < 4; l++) begin
                host.rd((o < 12) ? wff_pkg::PAGE_WAKE : wff_pkg::PAGE_MIRROR, 4'(o), rdVal);
                chk("reset read", 128'h0, rdVal);
            end
        end
        chk("reset out", 128'h0, {wakeMask});
        chk("reset cfg", 128'h0, {filterCrc, filterLastByte, rxConfig, irqMask});
        chk("reset misc", 128'h0, {filterByteOffset, txConfig, dataConfig,
            filterEnable, destMatchEnable, mcastMatchEnable});
    endtask : t_reset

    task automatic t_mirror;
        logic [7:0] cv [4] = '{8'h81, 8'h42, 8'h24, 8'h18};
        for (int i = 0; i < 4; i++) host.wr(wff_pkg::PAGE_CFG, 4'hC + 4'(i), cv[i]);
        for (int i = 0; i < 4; i++) host.wr(wff_pkg::PAGE_MIRROR, 4'hC + 4'(i), 8'hFF);
        for (int i = 0; i < 4; i++) begin
            host.rd(wff_pkg::PAGE_MIRROR, 4'hC + 4'(i), rdVal);
            chk("mirror read", cv[i], rdVal);
        end
        chk("cfg out", {cv[3], cv[2], cv[1], cv[0]}, {irqMask, dataConfig, txConfig, rxConfig});
    endtask : t_mirror

    task automatic t_words;
        logic [31:0] ov;
        logic [31:0] wd;
        for (int o = 1; o < 9; o++) begin
            wd = wv(4'(o));
            for (int l = 0; l < 4; l++) host.wr(wff_pkg::PAGE_WAKE, 4'(o), wd[8*l+:8]);
        end
        repeat (3) @(posedge core_clk);
        ov = wv(4'h7);
        chk("wakeMask", {wv(4'h4), wv(4'h3), wv(4'h2), wv(4'h1)}, wakeMask);
        chk("filterCrc", {wv(4'h6), wv(4'h5)}, filterCrc);
        chk("byteOffset", {ov[31:24], 1'b0, ov[23:16], 1'b0, ov[15:8], 1'b0, ov[7:0], 1'b0},
            filterByteOffset);
        chk("lastByte", wv(4'h8), filterLastByte);
        for (int o = 1; o < 9; o++) begin
            wd = wv(4'(o));
            for (int l = 0; l < 4; l++) begin
                host.rd(wff_pkg::PAGE_WAKE, 4'(o), rdVal);
                chk("word read", wd[8*l+:8], rdVal);
            end
        end
    endtask : t_words

    task automatic t_command;
        logic [7:0] cd [4] = '{8'h5A, 8'hC3, 8'hFF, 8'hFF};
        logic [7:0] ce [4] = '{8'h52, 8'h43, 8'h00, 8'h00};
        for (int l = 0; l < 4; l++) host.wr(wff_pkg::PAGE_WAKE, 4'h9, cd[l]);
        host.wr(wff_pkg::PAGE_WAKE, 4'hA, 8'h77);
        repeat (3) @(posedge core_clk);
        chk("cmd bits", 12'h65A, {filterEnable, destMatchEnable, mcastMatchEnable});
        for (int l = 0; l < 4; l++) begin
            host.rd(wff_pkg::PAGE_WAKE, 4'h9, rdVal);
            chk("cmd read", ce[l], rdVal);
        end
        host.rd(wff_pkg::PAGE_WAKE, 4'hA, rdVal);
        chk("unmapped read", 8'h00, rdVal);
    endtask : t_command

    task automatic t_realign;
        host.wr(wff_pkg::PAGE_WAKE, 4'h8, 8'h11);
        host.wr(wff_pkg::PAGE_WAKE, 4'h8, 8'h22);
        srst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        srst = 1'b0;
        chk("reset lastByte", 32'h0, filterLastByte);
        for (int l = 0; l < 4; l++) host.wr(wff_pkg::PAGE_WAKE, 4'h8, 8'hC0 + 8'(l));
        repeat (2) @(posedge core_clk);
        chk("realigned", 32'hC3C2_C1C0, filterLastByte);
    endtask : t_realign

    initial begin
        srst = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        srst = 1'b0;
        t_reset();
        t_mirror();
        t_words();
        t_command();
        t_realign();
        tally_and_finish();
    end

    initial begin
        #(3_000_000);
        miscompares++;
        tally_and_finish();
    end
endmodule : wff_filter_config_tb
`default_nettype wire
